// file: abd_pkg.sv
// Package with opcodes, flag positions, register map and cycle counts of the branch/ALU datapath.
package abd_pkg;

    // Status flag bit positions.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Reset values.
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    // APB register byte offsets.
    localparam logic [11:0] REG_FLAGS = 12'h000;
    localparam logic [11:0] REG_PC = 12'h004;
    localparam logic [11:0] REG_RETIRED = 12'h008;

    // Cycle counts per operation class.
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_WORD = 2'h2;
    localparam logic [1:0] CYC_JUMP = 2'h2;
    localparam logic [1:0] CYC_CALL = 2'h3;
    localparam logic [1:0] CYC_IOBIT = 2'h2;
    localparam logic [1:0] CYC_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP1 = 2'h2;
    localparam logic [1:0] CYC_SKIP2 = 2'h3;

    // Program counter steps.
    localparam logic [1:0] PC_STEP = 2'h1;
    localparam logic [1:0] PC_SKIP1 = 2'h2;
    localparam logic [1:0] PC_SKIP2 = 2'h3;

    // Operations presented by the decoder; constant forms reuse the register forms.
    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SUB_C, OP_AND, OP_OR, OP_XOR,
        OP_SET_BITS, OP_CLR_BITS, OP_TEST, OP_CP, OP_CMP_C,
        OP_SHL, OP_SHR, OP_RLC, OP_RRC, OP_ADD_WORD, OP_SUB_WORD,
        OP_JMP_PTR, OP_JMP_REL, OP_CALL_PTR, OP_CALL_REL,
        OP_CMP_SKIP, OP_SKIP_RBC, OP_SKIP_RBS, OP_SKIP_IOC, OP_SKIP_IOS,
        OP_BR_SET, OP_BR_CLR, OP_BR_GE, OP_BR_LT, OP_BR_UGE, OP_BR_ULT,
        OP_BR_IE, OP_BR_ID, OP_IO_SET, OP_IO_CLR
    } abd_op_t;

endpackage

// file: abd_alu.sv
// Combinational 8/16-bit arithmetic unit producing result and new status flags.
`timescale 1ns/10ps
module abd_alu import abd_pkg::*; (
    // Operation and operands
    input wire abd_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] a_hi,
    input wire logic [7:0] b,
    input wire logic [7:0] flags_in,
    // Results
    output logic [7:0] res,
    output logic [7:0] res_hi,
    output logic [7:0] flags_out
);
    logic cin;
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [15:0] wsum;
    logic [15:0] wdif;

    // Carry enters only the with-carry forms.
    assign cin = flags_in[FLAG_C] & (op == OP_ADC || op == OP_SUB_C || op == OP_CMP_C);
    assign sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign dif9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    // Word constant is six bits wide, so the top two bits of b are ignored.
    assign wsum = {a_hi, a} + {10'h000, b[5:0]};
    assign wdif = {a_hi, a} - {10'h000, b[5:0]};

    // Result and flag selection per operation.
    always_comb begin
        res = a;
        res_hi = a_hi;
        flags_out = flags_in;
        case (op)
            OP_ADD, OP_ADC: begin
                res = sum9[7:0];
                flags_out[FLAG_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
                flags_out[FLAG_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
                flags_out[FLAG_C] = sum9[8];
            end
            OP_SUB, OP_SUB_C, OP_CP, OP_CMP_C: begin
                res = dif9[7:0];
                flags_out[FLAG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
                flags_out[FLAG_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
                flags_out[FLAG_C] = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
            end
            OP_AND, OP_TEST: res = a & b;
            OP_OR, OP_SET_BITS: res = a | b;
            OP_XOR: res = a ^ b;
            OP_CLR_BITS: res = a & ~b;
            OP_SHL: res = {a[6:0], 1'b0};
            OP_SHR: res = {1'b0, a[7:1]};
            OP_RLC: res = {a[6:0], flags_in[FLAG_C]};
            OP_RRC: res = {flags_in[FLAG_C], a[7:1]};
            OP_ADD_WORD: begin
                {res_hi, res} = wsum;
                flags_out[FLAG_V] = ~a_hi[7] & res_hi[7];
                flags_out[FLAG_C] = ~res_hi[7] & a_hi[7];
            end
            OP_SUB_WORD: begin
                {res_hi, res} = wdif;
                flags_out[FLAG_V] = a_hi[7] & ~res_hi[7];
                flags_out[FLAG_C] = res_hi[7] & ~a_hi[7];
            end
            default: ;
        endcase
        // Logic forms clear overflow and keep carry; shifts move the lost bit into carry.
        case (op)
            OP_AND, OP_TEST, OP_OR, OP_SET_BITS, OP_XOR, OP_CLR_BITS: flags_out[FLAG_V] = 1'b0;
            OP_SHL, OP_RLC: flags_out[FLAG_C] = a[7];
            OP_SHR, OP_RRC: flags_out[FLAG_C] = a[0];
            default: ;
        endcase
        flags_out[FLAG_N] = (op == OP_ADD_WORD || op == OP_SUB_WORD) ? res_hi[7] : res[7];
        if (op == OP_SHL || op == OP_SHR || op == OP_RLC || op == OP_RRC) begin
            flags_out[FLAG_V] = flags_out[FLAG_N] ^ flags_out[FLAG_C];
        end
        if (op == OP_ADD_WORD || op == OP_SUB_WORD) begin
            flags_out[FLAG_Z] = ({res_hi, res} == 16'h0000);
            flags_out[FLAG_S] = flags_out[FLAG_N] ^ flags_out[FLAG_V];
        end else if (op == OP_SUB_C || op == OP_CMP_C) begin
            // With-carry subtracts keep zero only if it was already set.
            flags_out[FLAG_Z] = (res == 8'h00) & flags_in[FLAG_Z];
        end else begin
            flags_out[FLAG_Z] = (res == 8'h00);
        end
    end
endmodule

// file: abd_exec.sv
// Execution datapath: ALU sequencing, branches, skips, I/O bit operations and APB status access.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module abd_exec import abd_pkg::*; #(
    parameter int PC_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder request
    input wire logic op_valid,
    input wire abd_op_t op_code,
    input wire logic [7:0] op_dst_val,
    input wire logic [7:0] op_dst_hi_val,
    input wire logic [7:0] op_src_val,
    input wire logic [2:0] op_bit,
    input wire logic [11:0] op_offset,
    input wire logic op_next_two_word,
    input wire logic [4:0] op_io_addr,
    input wire logic [PC_W-1:0] z_pointer,
    output logic op_ready,
    // Register file write-back
    output logic res_we,
    output logic res_pair,
    output logic [7:0] res_data,
    output logic [7:0] res_data_hi,
    // Program counter and call return address
    output logic [PC_W-1:0] pc,
    output logic call_push,
    output logic [PC_W-1:0] call_ret_addr,
    // I/O bit space
    output logic [4:0] io_addr,
    input wire logic [7:0] io_rdata,
    output logic io_we,
    output logic [7:0] io_wdata,
    // Status flags
    output logic [7:0] status_flags_register
);
    logic acc;
    logic [1:0] busy_cnt;
    logic [7:0] alu_res;
    logic [7:0] alu_res_hi;
    logic [7:0] alu_flags;
    logic does_write;
    logic does_pair;
    logic does_flags;
    logic take;
    logic skip;
    logic is_branch;
    logic is_skip;
    logic [7:0] bit_mask;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] next_pc;
    logic [1:0] next_cycles;
    logic [4:0] io_wr_addr;
    logic [31:0] retired;
    logic apb_setup;
    logic apb_wr;

    // Arithmetic unit shared by every data operation.
    abd_alu u_alu (
        .op(op_code),
        .a(op_dst_val),
        .a_hi(op_dst_hi_val),
        .b(op_src_val),
        .flags_in(status_flags_register),
        .res(alu_res),
        .res_hi(alu_res_hi),
        .flags_out(alu_flags)
    );

    // A request is taken only while no multi-cycle operation is still running.
    assign op_ready = (busy_cnt == 2'h0);
    assign acc = op_valid & op_ready;
    assign bit_mask = 8'h01 << op_bit;
    assign rel_target = PC_W'(pc + {{(PC_W-12){op_offset[11]}}, op_offset} + PC_W'(PC_STEP));

    // The I/O address follows the request for reads, then holds for the delayed write.
    assign io_addr = acc ? op_io_addr : io_wr_addr;

    // Which operations write back, write a pair, or touch the flags.
    always_comb begin
        does_write = 1'b0;
        does_pair = 1'b0;
        does_flags = 1'b0;
        case (op_code)
            OP_ADD, OP_ADC, OP_SUB, OP_SUB_C: begin
                does_write = 1'b1;
                does_flags = 1'b1;
            end
            OP_AND, OP_OR, OP_XOR, OP_SET_BITS, OP_CLR_BITS, OP_TEST: begin
                does_write = 1'b1;
                does_flags = 1'b1;
            end
            OP_SHL, OP_SHR, OP_RLC, OP_RRC: begin
                does_write = 1'b1;
                does_flags = 1'b1;
            end
            OP_ADD_WORD, OP_SUB_WORD: begin
                does_write = 1'b1;
                does_pair = 1'b1;
                does_flags = 1'b1;
            end
            OP_CP, OP_CMP_C: does_flags = 1'b1;
            default: ;
        endcase
    end

    // Branch condition from the flag register.
    always_comb begin
        is_branch = 1'b1;
        take = 1'b0;
        case (op_code)
            OP_BR_SET: take = status_flags_register[op_bit];
            OP_BR_CLR: take = ~status_flags_register[op_bit];
            OP_BR_GE: take = ~(status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V]);
            OP_BR_LT: take = status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V];
            OP_BR_UGE: take = ~status_flags_register[FLAG_C];
            OP_BR_ULT: take = status_flags_register[FLAG_C];
            OP_BR_IE: take = status_flags_register[FLAG_I];
            OP_BR_ID: take = ~status_flags_register[FLAG_I];
            default: is_branch = 1'b0;
        endcase
    end

    // Skip condition; register skips test the source operand, I/O skips the read data.
    always_comb begin
        is_skip = 1'b1;
        skip = 1'b0;
        case (op_code)
            OP_CMP_SKIP: skip = (op_dst_val == op_src_val);
            OP_SKIP_RBC: skip = ~op_src_val[op_bit];
            OP_SKIP_RBS: skip = op_src_val[op_bit];
            OP_SKIP_IOC: skip = ~io_rdata[op_bit];
            OP_SKIP_IOS: skip = io_rdata[op_bit];
            default: is_skip = 1'b0;
        endcase
    end

    // Next program counter and total cycle count of the request.
    always_comb begin
        next_pc = PC_W'(pc + PC_W'(PC_STEP));
        next_cycles = CYC_ONE;
        if (op_code == OP_JMP_PTR) begin
            next_pc = z_pointer;
            next_cycles = CYC_JUMP;
        end else if (op_code == OP_JMP_REL) begin
            next_pc = rel_target;
            next_cycles = CYC_JUMP;
        end else if (op_code == OP_CALL_PTR) begin
            next_pc = z_pointer;
            next_cycles = CYC_CALL;
        end else if (op_code == OP_CALL_REL) begin
            next_pc = rel_target;
            next_cycles = CYC_CALL;
        end else if (op_code == OP_ADD_WORD || op_code == OP_SUB_WORD) begin
            next_cycles = CYC_WORD;
        end else if (op_code == OP_IO_SET || op_code == OP_IO_CLR) begin
            next_cycles = CYC_IOBIT;
        end else if (is_branch && take) begin
            next_pc = rel_target;
            next_cycles = CYC_TAKEN;
        end else if (is_skip && skip && op_next_two_word) begin
            next_pc = PC_W'(pc + PC_W'(PC_SKIP2));
            next_cycles = CYC_SKIP2;
        end else if (is_skip && skip) begin
            next_pc = PC_W'(pc + PC_W'(PC_SKIP1));
            next_cycles = CYC_SKIP1;
        end
    end

    // Stall counter; holds off the decoder for the remaining cycles of the operation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 2'h0;
        end else if (acc) begin
            busy_cnt <= next_cycles - CYC_ONE;
        end else if (busy_cnt != 2'h0) begin
            busy_cnt <= busy_cnt - 2'h1;
        end
    end

    // Program counter; an executing operation wins over a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PC_W'(PC_RST);
        end else if (acc) begin
            pc <= next_pc;
        end else if (apb_wr && paddr == REG_PC) begin
            pc <= pwdata[PC_W-1:0];
        end
    end

    // Status flags; flagless operations leave them alone, so hardware updates win over software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_flags_register <= FLAGS_RST;
        end else if (acc && does_flags) begin
            status_flags_register <= alu_flags;
        end else if (apb_wr && paddr == REG_FLAGS) begin
            status_flags_register <= pwdata[7:0];
        end
    end

    // Register file write-back, presented one cycle after the request is taken.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_we <= 1'b0;
            res_pair <= 1'b0;
            res_data <= 8'h00;
            res_data_hi <= 8'h00;
        end else begin
            res_we <= acc & does_write;
            res_pair <= acc & does_pair;
            if (acc && does_write) begin
                res_data <= alu_res;
                res_data_hi <= alu_res_hi;
            end
        end
    end

    // Return address for the stack logic of a call.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_push <= 1'b0;
            call_ret_addr <= PC_W'(PC_RST);
        end else begin
            call_push <= acc & (op_code == OP_CALL_PTR || op_code == OP_CALL_REL);
            if (acc) begin
                call_ret_addr <= PC_W'(pc + PC_W'(PC_STEP));
            end
        end
    end

    // I/O bit write; read in the first cycle, single bit changed in the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_we <= 1'b0;
            io_wdata <= 8'h00;
            io_wr_addr <= 5'h00;
        end else begin
            io_we <= acc & (op_code == OP_IO_SET || op_code == OP_IO_CLR);
            if (acc) begin
                io_wr_addr <= op_io_addr;
                io_wdata <= (op_code == OP_IO_SET) ? (io_rdata | bit_mask) : (io_rdata & ~bit_mask);
            end
        end
    end

    // Retired operation counter for software progress checks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retired <= 32'h0000_0000;
        end else if (acc) begin
            retired <= retired + 32'h0000_0001;
        end
    end

    // APB: zero wait states; read data is captured in the setup cycle.
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;

    // Read mux and error for unmapped offsets; state changing during setup shows on the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (paddr == REG_FLAGS) begin
                prdata <= {24'h000000, status_flags_register};
            end else if (paddr == REG_PC) begin
                prdata <= 32'(pc);
            end else if (paddr == REG_RETIRED) begin
                prdata <= retired;
            end else begin
                pslverr <= 1'b1;
            end
        end
    end

    // Checks on the observable behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    add_sum_a: assert property (acc && op_code == OP_ADD |=> res_we && res_data == $past(op_dst_val + op_src_val))
        else $error("add result wrong");
    word_stall_a: assert property (acc && (op_code == OP_ADD_WORD || op_code == OP_SUB_WORD)
        |=> !op_ready ##1 op_ready && !res_we)
        else $error("word operation not two cycles");
    logic_carry_a: assert property (acc && op_code == OP_AND |=>
        status_flags_register[FLAG_C] == $past(status_flags_register[FLAG_C]) && !status_flags_register[FLAG_V])
        else $error("logic operation disturbed carry");
    ptr_jump_a: assert property (acc && op_code == OP_JMP_PTR |=> pc == $past(z_pointer) && !op_ready)
        else $error("pointer jump wrong");
    call_stall_a: assert property (acc && (op_code == OP_CALL_PTR || op_code == OP_CALL_REL)
        |=> call_push ##0 !op_ready [*2] ##1 op_ready)
        else $error("call not three cycles");
    skip_equal_a: assert property (acc && op_code == OP_CMP_SKIP && op_dst_val == op_src_val && !op_next_two_word
        |=> pc == PC_W'($past(pc) + PC_W'(PC_SKIP1)) ##1 op_ready)
        else $error("skip step wrong");
    branch_not_a: assert property (acc && is_branch && !take
        |=> op_ready && pc == PC_W'($past(pc) + PC_W'(PC_STEP)))
        else $error("untaken branch wrong");
    signed_ge_a: assert property (acc && op_code == OP_BR_GE
        && status_flags_register[FLAG_N] == status_flags_register[FLAG_V] |=> pc == $past(rel_target))
        else $error("signed branch wrong");
    io_bit_a: assert property (acc && op_code == OP_IO_SET
        |=> io_we && io_wdata == ($past(io_rdata) | $past(bit_mask)) && status_flags_register == $past(status_flags_register))
        else $error("I/O bit set wrong");

    word_cov_c: cover property (acc && op_code == OP_SUB_WORD ##1 res_pair);
    taken_cov_c: cover property (acc && is_branch && take ##1 !op_ready);
    skip2_cov_c: cover property (acc && is_skip && skip && op_next_two_word);
    apb_cov_c: cover property (apb_wr && paddr == REG_FLAGS);
endmodule

// file: abd_io_model.sv
// I/O bit space model that answers reads and takes single-byte writes.
`timescale 1ns/10ps
module abd_io_model (
    // Clock
    input wire logic pclk,
    // Access from the datapath
    input wire logic [4:0] io_addr,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata
);
    logic [7:0] mem [32];
    // A known start pattern lets the bench keep a mirror without peeking here.
    initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 29);
    // Reads are combinational because the datapath samples them in the accept cycle.
    assign io_rdata = mem[io_addr];
    // A write lands at the edge that closes the write pulse; a plain always, as the initial preloads the array too.
    always @(posedge pclk) begin
        if (io_we) mem[io_addr] <= io_wdata;
    end
endmodule

// file: test_alu_branch_datapath.sv
// Self-checking bench for the execution datapath and its I/O space model.
`timescale 1ns/10ps
module test_alu_branch_datapath import abd_pkg::*;;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, op_valid = 1'h0;
    logic op_next_two_word = 1'h0, pready, pslverr, op_ready, res_we, res_pair, call_push, io_we, err, t, tw;
    logic [11:0] paddr = 12'h000, op_offset = 12'h000, k;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] op_dst_val = 8'h00, op_dst_hi_val = 8'h00, op_src_val = 8'h00, res_data, res_data_hi;
    logic [7:0] io_rdata, io_wdata, status_flags_register, eflg, a, b, r, eio [32];
    logic [2:0] op_bit = 3'h0, bt;
    logic [4:0] op_io_addr = 5'h00, io_addr, ia;
    logic [15:0] z_pointer = 16'h0000, pc, call_ret_addr, epc, ret, p;
    logic [16:0] w, expq [$];
    abd_op_t op_code = OP_NOP, c;
    int num_errors = 0, num_checks = 0, cyc, nret = 0, tick = 0;

    abd_exec dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .op_valid, .op_code, .op_dst_val, .op_dst_hi_val, .op_src_val, .op_bit, .op_offset, .op_next_two_word,
        .op_io_addr, .z_pointer, .op_ready, .res_we, .res_pair, .res_data, .res_data_hi, .pc, .call_push,
        .call_ret_addr, .io_addr, .io_rdata, .io_we, .io_wdata, .status_flags_register);
    abd_io_model io_u (.pclk, .io_addr, .io_we, .io_wdata, .io_rdata);

    // Free-running 50 MHz clock.
    always #10 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Write-backs are matched in order against the notes left by the driver; a stray one is a mismatch.
    always @(posedge pclk) begin
        if (res_we === 1'h1) begin
            if (expq.size() == 0) chk(32'h1, 32'h0);
            else chk({res_pair, res_pair ? res_data_hi : 8'h00, res_data}, expq.pop_front());
        end
        tick++;
        if (tick > 20000) begin
            num_errors++;
            test_done();
        end
    end

    // One APB transfer; an idle edge follows so psel is never driven twice in one step.
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (wr && ad == REG_FLAGS) eflg = d[7:0];
        if (wr && ad == REG_PC) epc = d[15:0];
        @(posedge pclk);
    endtask

    // Issues one operation, waits out its busy time and checks the settled state.
    task automatic op(input abd_op_t oc, input logic [7:0] x, input logic [7:0] y, input int n);
        op_valid <= 1'h1;
        op_code <= oc;
        op_dst_val <= x;
        op_src_val <= y;
        @(posedge pclk);
        op_valid <= 1'h0;
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (op_ready !== 1'h1 && cyc < 8);
        nret++;
        chk(32'(cyc), 32'(n));
        chk(pc, epc);
        chk(status_flags_register, eflg);
    endtask

    // Reference byte result; it also moves the expected flags on.
    function automatic logic [7:0] alu(input abd_op_t oc, input logic [7:0] x, input logic [7:0] y);
        logic ci;
        logic sub;
        logic ar;
        logic [4:0] h;
        logic [8:0] s;
        ci = eflg[FLAG_C] & (oc inside {OP_ADC, OP_SUB_C, OP_CMP_C});
        sub = oc inside {OP_SUB, OP_SUB_C, OP_CP, OP_CMP_C};
        ar = sub | (oc inside {OP_ADD, OP_ADC});
        h = sub ? x[3:0] - y[3:0] - ci : x[3:0] + y[3:0] + ci;
        s = sub ? x - y - ci : x + y + ci;
        case (oc)
            OP_AND, OP_TEST: s = {eflg[FLAG_C], x & y};
            OP_OR, OP_SET_BITS: s = {eflg[FLAG_C], x | y};
            OP_XOR: s = {eflg[FLAG_C], x ^ y};
            OP_CLR_BITS: s = {eflg[FLAG_C], x & ~y};
            OP_SHL: s = {x, 1'h0};
            OP_SHR: s = {x[0], 1'h0, x[7:1]};
            OP_RLC: s = {x, eflg[FLAG_C]};
            OP_RRC: s = {x[0], eflg[FLAG_C], x[7:1]};
            default: ;
        endcase
        eflg[FLAG_Z] = (s[7:0] == 8'h00) & (eflg[FLAG_Z] | !(oc inside {OP_SUB_C, OP_CMP_C}));
        eflg[FLAG_N] = s[7];
        eflg[FLAG_C] = s[8];
        if (ar) eflg[FLAG_H] = h[4];
        eflg[FLAG_V] = ar ? (x[7] ^ y[7] ^ !sub) & (s[7] ^ x[7]) : (oc >= OP_SHL) & (s[7] ^ s[8]);
        return s[7:0];
    endfunction

    // Main sequence: reset, registers, then every operation family.
    initial begin
        void'($urandom(57));
        for (int i = 0; i < 32; i++) eio[i] = 8'(i * 29);
        epc = PC_RST;
        eflg = FLAGS_RST;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk(pc, PC_RST);
        apb(1'h1, REG_FLAGS, 32'hFFFF_FFC0);
        apb(1'h0, REG_FLAGS, 32'h0);
        chk(rd, 32'hC0);
        apb(1'h1, REG_PC, 32'h0000_0100);
        apb(1'h0, REG_PC, 32'h0);
        chk(rd, 32'h100);
        apb(1'h0, 12'h00C, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        apb(1'h1, REG_RETIRED, 32'h55);
        for (int i = 0; i < 160; i++) begin
            c = abd_op_t'(6'(1 + i % 16));
            a = 8'($urandom);
            b = (c == OP_TEST) ? a : 8'($urandom);
            r = alu(c, a, b);
            if (!(c inside {OP_CP, OP_CMP_C})) expq.push_back({9'h000, r});
            epc++;
            op(c, a, b, 1);
        end
        for (int i = 0; i < 12; i++) begin
            p = 16'($urandom);
            b = 8'($urandom % 64);
            w = i[0] ? p - b : p + b;
            eflg[FLAG_C] = w[16];
            eflg[FLAG_Z] = w[15:0] == 16'h0000;
            eflg[FLAG_N] = w[15];
            eflg[FLAG_V] = i[0] ? p[15] & ~w[15] : ~p[15] & w[15];
            eflg[FLAG_S] = eflg[FLAG_N] ^ eflg[FLAG_V];
            expq.push_back({1'h1, w[15:0]});
            op_dst_hi_val <= p[15:8];
            epc++;
            op(i[0] ? OP_SUB_WORD : OP_ADD_WORD, p[7:0], b, 2);
        end
        for (int i = 0; i < 64; i++) begin
            apb(1'h1, REG_FLAGS, 32'($urandom) & 32'hFF);
            bt = 3'($urandom);
            k = 12'($urandom);
            t = 1'(8'({~eflg[FLAG_I], eflg[FLAG_I], eflg[FLAG_C], ~eflg[FLAG_C], eflg[FLAG_N] ^ eflg[FLAG_V],
                ~(eflg[FLAG_N] ^ eflg[FLAG_V]), ~eflg[bt], eflg[bt]}) >> (i % 8));
            op_bit <= bt;
            op_offset <= k;
            epc = epc + (t ? {{4{k[11]}}, k} : 16'h0000) + 16'h0001;
            op(abd_op_t'(6'(OP_BR_SET + i % 8)), 8'h00, 8'h00, t ? 2 : 1);
        end
        for (int i = 0; i < 8; i++) begin
            p = 16'($urandom);
            k = 12'($urandom);
            z_pointer <= p;
            op_offset <= k;
            ret = epc + 16'h0001;
            epc = i[0] ? epc + {{4{k[11]}}, k} + 16'h0001 : p;
            op(abd_op_t'(6'(OP_JMP_PTR + i % 4)), 8'h00, 8'h00, i[1] ? 3 : 2);
            if (i[1]) chk(call_ret_addr, ret);
        end
        for (int i = 0; i < 8; i++) begin
            ia = 5'($urandom);
            bt = 3'($urandom);
            eio[ia][bt] = ~i[0];
            op_io_addr <= ia;
            op_bit <= bt;
            epc++;
            op(i[0] ? OP_IO_CLR : OP_IO_SET, 8'h00, 8'h00, 2);
            chk({io_addr, io_wdata}, {ia, eio[ia]});
        end
        for (int i = 0; i < 40; i++) begin
            a = 8'($urandom);
            b = (i % 3 == 0) ? a : 8'($urandom);
            bt = 3'($urandom);
            ia = 5'($urandom);
            tw = 1'($urandom);
            t = 1'(5'({eio[ia][bt], ~eio[ia][bt], b[bt], ~b[bt], a == b}) >> (i % 5));
            op_bit <= bt;
            op_io_addr <= ia;
            op_next_two_word <= tw;
            epc = epc + (t ? (tw ? 16'h0003 : 16'h0002) : 16'h0001);
            op(abd_op_t'(6'(OP_CMP_SKIP + i % 5)), a, b, t ? (tw ? 3 : 2) : 1);
        end
        apb(1'h0, REG_RETIRED, 32'h0);
        chk(rd, 32'(nret));
        test_done();
    end
endmodule
